//--- design/program_sequencer.v
// Local design decision: the APB slave port.
`include "sequencer_defs.vh"

module program_sequencer #(
   parameter STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter SST_W          = 11
) (
   // clock and reset
   input  wire                pclk,
   input  wire                presetn,
   // apb slave
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [7:0]          paddr,
   input  wire [31:0]         pwdata,
   output reg  [31:0]         prdata,
   output reg                 pready,
   output reg                 pslverr,
   // program rom
   output reg  [`SEQ_AW-1:0]  rom_addr,
   input  wire [`ROM_DW-1:0]  rom_data,
   // decoder
   output reg  [`ROM_DW-1:0]  exec_word,
   output reg  [`SEQ_AW-1:0]  exec_addr,
   output reg                 exec_valid,
   output reg  [1:0]          phase,
   input  wire [3:0]          op_code,
   input  wire [`SEQ_AW-1:0]  op_target,
   input  wire                skip_true,
   // lookup result
   output reg  [7:0]          lookup_low_byte,
   output reg                 lookup_low_valid,
   // interrupt sources
   input  wire                ext_irq_first_n,
   input  wire                ext_irq_second_n,
   input  wire                counter_first_ovf,
   input  wire                counter_second_ovf,
   input  wire                time_base_irq,
   input  wire                rtc_irq,
   output reg  [5:0]          irq_ack,
   // power
   input  wire                wake_pin,
   output reg                 halted
);

   localparam [31:0]      SST_FULL = STARTUP_CYCLES - 1;
   localparam [SST_W-1:0] SST_LOAD = SST_FULL[SST_W-1:0];
   localparam [1:0]       PH_ONE   = 2'h1;
   localparam [11:0]      SEQ_ONE  = 12'h001;

   reg  [`SEQ_AW-1:0] seq_reg;
   reg  [7:0]         look_ptr_reg;
   reg  [6:0]         look_high_reg;
   reg  [7:0]         low_val_reg;
   reg                low_pend_reg;
   reg  [5:0]         irq_en_reg;
   reg  [5:0]         pend_reg;
   reg                lookup_reg;
   reg                held_valid_reg;
   reg  [SST_W-1:0]   sst_cnt_reg;
   reg                busy_reg;
   reg  [2:0]         first_sync_reg;
   reg  [2:0]         second_sync_reg;
   reg  [1:0]         wake_sync_reg;

   reg  [`SEQ_AW-1:0] seq_next;
   reg  [`SEQ_AW-1:0] rom_next;
   reg                valid_next;
   reg                push;
   reg                pop;
   reg                look_start;
   reg                halt_go;
   reg                low_taken;
   reg  [5:0]         ack_next;
   reg  [2:0]         irq_sel;
   reg                irq_any;
   reg  [`SEQ_AW-1:0] irq_vec;
   reg  [`SEQ_AW-1:0] look_addr;
   reg  [31:0]        rd_next;
   reg                err_next;
   integer            k;

   wire               stack_full;
   wire [2:0]         stack_level;
   wire [`SEQ_AW-1:0] stack_top;
   wire [5:0]         irq_set;
   wire [5:0]         irq_ready;
   wire               running;
   wire               boundary;
   wire               apb_write;
   wire [5:0]         reg_idx;
   wire               op_moves;

   assign running   = !busy_reg && !halted;
   assign boundary  = running && (phase == `PHASE_LAST);
   assign apb_write = psel && penable && pready && pwrite;
   assign reg_idx   = paddr[7:2];
   assign irq_ready = pend_reg & irq_en_reg;
   // a false skip behaves like a plain sequential instruction
   assign op_moves  = exec_valid && (op_code != `OP_SEQ) &&
                      !(op_code == `OP_SKIP && !skip_true);

   // pins are synchronised; edges are taken from the second and third stages
   assign irq_set = {rtc_irq, time_base_irq, counter_second_ovf, counter_first_ovf,
                     second_sync_reg[2] & ~second_sync_reg[1],
                     first_sync_reg[2] & ~first_sync_reg[1]};

   return_stack #(
      .DEPTH (`STACK_DEPTH),
      .AW    (`SEQ_AW),
      .IW    (`STACK_IW)
   ) stack_u (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (push),
      .pop       (pop),
      .push_addr (seq_reg), // fetched word, not yet run
      .top_addr  (stack_top),
      .level_reg (stack_level),
      .full      (stack_full)
   );

   // lowest vector wins, others stay pending
   always @* begin
      irq_sel = 3'h0;
      irq_any = 1'b0;
      for (k = `IRQ_SOURCES - 1; k >= 0; k = k - 1) begin
         if (irq_ready[k]) begin
            irq_sel = k[2:0];
            irq_any = 1'b1;
         end
      end
      case (irq_sel)
         3'h0:    irq_vec = `VEC_EXT_FIRST;
         3'h1:    irq_vec = `VEC_EXT_SECOND;
         3'h2:    irq_vec = `VEC_CNT_FIRST;
         3'h3:    irq_vec = `VEC_CNT_SECOND;
         3'h4:    irq_vec = `VEC_TIME_BASE;
         3'h5:    irq_vec = `VEC_RTC;
         default: irq_vec = `VEC_RESET;
      endcase
   end

   always @* begin
      look_addr = {(op_code == `OP_RD_LAST) ? `LAST_PAGE : exec_addr[11:8], look_ptr_reg};
   end

   // decision taken at the end of each instruction cycle
   always @* begin
      seq_next   = seq_reg + SEQ_ONE;
      valid_next = 1'b1;
      push       = 1'b0;
      pop        = 1'b0;
      look_start = 1'b0;
      halt_go    = 1'b0;
      low_taken  = 1'b0;
      ack_next   = 6'h00;
      if (!boundary) begin
         seq_next   = seq_reg;
         valid_next = exec_valid;
      end else if (lookup_reg) begin
         // fetched word was held through the lookup cycle
         seq_next   = seq_reg;
         valid_next = held_valid_reg;
      end else if (op_moves) begin
         valid_next = 1'b0;
         case (op_code)
            `OP_SKIP:     seq_next = seq_reg + SEQ_ONE;
            `OP_JUMP:     seq_next = op_target;
            `OP_CALL: begin
               // a call on a full stack drops the oldest entry
               seq_next = op_target;
               push     = 1'b1;
            end
            `OP_SUB_RETURN, `OP_IRQ_RETURN: begin
               seq_next = stack_top;
               pop      = 1'b1;
            end
            `OP_RD_CURRENT, `OP_RD_LAST: look_start = 1'b1;
            `OP_LOAD_LOW: seq_next = {seq_reg[11:8], op_target[7:0]};
            `OP_HALT: begin
               seq_next = seq_reg;
               halt_go  = 1'b1;
            end
            default:      valid_next = 1'b1;
         endcase
      end else if (low_pend_reg) begin
         seq_next   = {seq_reg[11:8], low_val_reg};
         valid_next = 1'b0;
         low_taken  = 1'b1;
      end else if (irq_any && !stack_full) begin
         // full stack leaves the request pending until a return
         seq_next   = irq_vec;
         valid_next = 1'b0;
         push       = 1'b1;
         ack_next   = 6'h01 << irq_sel;
      end
      rom_next = look_start ? look_addr : seq_next;
   end

   // apb read mux and error decode
   always @* begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      case (reg_idx)
         `IDX_SEQ_LOW:    rd_next[7:0] = exec_addr[7:0];
         `IDX_LOOK_PTR:   rd_next[7:0] = look_ptr_reg;
         `IDX_LOOK_HIGH: begin
            rd_next[6:0] = look_high_reg;
            err_next     = pwrite;
         end
         `IDX_IRQ_ENABLE: rd_next[5:0] = irq_en_reg;
         `IDX_STATUS: begin
            rd_next[`ST_SEQ_LSB+11:`ST_SEQ_LSB]     = seq_reg;
            rd_next[`ST_LEVEL_LSB+2:`ST_LEVEL_LSB] = stack_level;
            rd_next[`ST_BUSY_BIT]                  = busy_reg;
            rd_next[`ST_HALT_BIT]                  = halted;
            rd_next[`ST_PEND_LSB+5:`ST_PEND_LSB]   = pend_reg;
         end
         default: err_next = 1'b1;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         // one access cycle per transfer
         pready  <= psel && !penable;
         prdata  <= (psel && !penable && !pwrite) ? rd_next : 32'h0000_0000;
         pslverr <= psel && !penable && err_next;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         look_ptr_reg <= 8'h00;
         irq_en_reg   <= 6'h00;
         low_val_reg  <= 8'h00;
         low_pend_reg <= 1'b0;
      end else begin
         if (apb_write && reg_idx == `IDX_LOOK_PTR) begin
            look_ptr_reg <= pwdata[7:0];
         end
         if (apb_write && reg_idx == `IDX_IRQ_ENABLE) begin
            irq_en_reg <= pwdata[5:0];
         end
         if (apb_write && reg_idx == `IDX_SEQ_LOW) begin
            low_val_reg  <= pwdata[7:0];
            low_pend_reg <= 1'b1;
         end else if (low_taken) begin
            low_pend_reg <= 1'b0;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_sync_reg  <= 3'h7;
         second_sync_reg <= 3'h7;
         wake_sync_reg   <= 2'h0;
         pend_reg        <= 6'h00;
         irq_ack         <= 6'h00;
      end else begin
         first_sync_reg  <= {first_sync_reg[1:0], ext_irq_first_n};
         second_sync_reg <= {second_sync_reg[1:0], ext_irq_second_n};
         wake_sync_reg   <= {wake_sync_reg[0], wake_pin};
         // a new request in the acknowledge cycle survives
         pend_reg        <= (pend_reg & ~ack_next) | irq_set;
         irq_ack         <= ack_next;
      end
   end

   // start-up timer and halt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sst_cnt_reg <= SST_LOAD;
         busy_reg    <= 1'b1;
         halted      <= 1'b0;
      end else if (halted) begin
         if (wake_sync_reg[1]) begin
            halted      <= 1'b0;
            busy_reg    <= 1'b1;
            sst_cnt_reg <= SST_LOAD;
         end
      end else if (busy_reg) begin
         if (sst_cnt_reg == {SST_W{1'b0}}) begin
            busy_reg <= 1'b0;
         end else begin
            sst_cnt_reg <= sst_cnt_reg - {{(SST_W-1){1'b0}}, 1'b1};
         end
      end else if (halt_go) begin
         halted <= 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_reg          <= `VEC_RESET;
         rom_addr         <= `VEC_RESET;
         phase            <= 2'h0;
         exec_word        <= {`ROM_DW{1'b0}};
         exec_addr        <= `VEC_RESET;
         exec_valid       <= 1'b0;
         lookup_reg       <= 1'b0;
         held_valid_reg   <= 1'b0;
         look_high_reg    <= 7'h00;
         lookup_low_byte  <= 8'h00;
         lookup_low_valid <= 1'b0;
      end else begin
         lookup_low_valid <= 1'b0;
         if (!running) begin
            phase <= 2'h0;
         end else begin
            phase <= phase + PH_ONE;
         end
         if (boundary) begin
            seq_reg    <= seq_next;
            rom_addr   <= rom_next;
            exec_valid <= valid_next;
            lookup_reg <= look_start;
            if (lookup_reg) begin
               look_high_reg    <= rom_data[14:8];
               lookup_low_byte  <= rom_data[7:0];
               lookup_low_valid <= 1'b1;
            end else if (look_start) begin
               // keep the fetched word and run it after the lookup cycle
               exec_word      <= rom_data;
               exec_addr      <= seq_reg;
               held_valid_reg <= 1'b1;
               seq_reg        <= seq_reg + SEQ_ONE;
               rom_addr       <= look_addr;
            end else begin
               exec_word <= rom_data;
               exec_addr <= seq_reg;
            end
         end
      end
   end

endmodule

//--- design/return_stack.v
`include "sequencer_defs.vh"

module return_stack #(
   parameter DEPTH = `STACK_DEPTH,
   parameter AW    = `SEQ_AW,
   parameter IW    = `STACK_IW
) (
   // clock and reset
   input  wire          pclk,
   input  wire          presetn,
   // stack operations
   input  wire          push,
   input  wire          pop,
   input  wire [AW-1:0] push_addr,
   // state
   output wire [AW-1:0] top_addr,
   output reg  [IW-1:0] level_reg,
   output wire          full
);

   localparam [31:0]   DEPTH_W    = DEPTH;
   localparam [IW-1:0] FULL_LEVEL = DEPTH_W[IW-1:0];
   localparam [IW-1:0] ONE        = {{(IW-1){1'b0}}, 1'b1};

   wire [AW-1:0] entry [0:DEPTH];

   assign entry[DEPTH] = {AW{1'b0}};
   assign top_addr     = entry[0];
   assign full         = (level_reg == FULL_LEVEL);

   // shift structure: a push past the last level drops the oldest entry
   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : level_g
         reg [AW-1:0] slot_reg;
         assign entry[i] = slot_reg;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               slot_reg <= {AW{1'b0}};
            end else if (push) begin
               if (i == 0) begin
                  slot_reg <= push_addr;
               end else begin
                  slot_reg <= entry[i-1];
               end
            end else if (pop) begin
               slot_reg <= entry[i+1];
            end
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= {IW{1'b0}};
      end else if (push && !full) begin
         level_reg <= level_reg + ONE;
      end else if (pop && !push && level_reg != {IW{1'b0}}) begin
         level_reg <= level_reg - ONE;
      end
   end

endmodule

//--- design/sequencer_defs.vh
`ifndef SEQUENCER_DEFS_VH
`define SEQUENCER_DEFS_VH

// geometry
`define SEQ_AW          12
`define ROM_DW          15
`define PHASES          4
`define PHASE_LAST      2'h3
`define STACK_DEPTH     6
`define STACK_IW        3

// start-up period, in system clock periods
`define STARTUP_TSYS    1024
`define STARTUP_CYCLES  (`STARTUP_TSYS * 1)

// fixed vectors
`define VEC_RESET       12'h000
`define VEC_EXT_FIRST   12'h004
`define VEC_EXT_SECOND  12'h008
`define VEC_CNT_FIRST   12'h00C
`define VEC_CNT_SECOND  12'h010
`define VEC_TIME_BASE   12'h014
`define VEC_RTC         12'h018
`define LAST_PAGE       4'hF
`define IRQ_SOURCES     6

// register indices, byte address is four times the index
`define IDX_SEQ_LOW     6'h06
`define IDX_LOOK_PTR    6'h07
`define IDX_LOOK_HIGH   6'h08
`define IDX_IRQ_ENABLE  6'h10
`define IDX_STATUS      6'h11

// status word fields
`define ST_SEQ_LSB      0
`define ST_LEVEL_LSB    12
`define ST_BUSY_BIT     15
`define ST_HALT_BIT     16
`define ST_PEND_LSB     17

// operation codes from the decoder
`define OP_SEQ          4'h0
`define OP_SKIP         4'h1
`define OP_JUMP         4'h2
`define OP_CALL         4'h3
`define OP_SUB_RETURN   4'h4
`define OP_IRQ_RETURN   4'h5
`define OP_RD_CURRENT   4'h6
`define OP_RD_LAST      4'h7
`define OP_LOAD_LOW     4'h8
`define OP_HALT         4'h9

`endif

//--- sim/rom_model.sv
module rom_model (
   // rom port
   input  wire logic        pclk,
   input  wire logic [11:0] rom_addr,
   output logic [14:0]      rom_data,
   // decoder view
   input  wire logic [14:0] exec_word,
   output logic [3:0]       op_code,
   output logic [11:0]      op_target,
   output logic             skip_true
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [14:0] mem_reg [0:4095];

   // one clock of access time, inside the three allowed
   always @(posedge pclk) rom_data <= mem_reg[rom_addr];
   // operation in the top four bits, target below, bit 10 doubles as skip condition
   assign op_code   = exec_word[14:11];
   assign op_target = {1'b0, exec_word[10:0]};
   assign skip_true = exec_word[10];
endmodule

//--- sim/seq_chk.sv
module seq_chk #(
   parameter STARTUP_CYCLES = 1024
) (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // sequencing
   input wire logic [11:0] rom_addr,
   input wire logic [11:0] exec_addr,
   input wire logic        exec_valid,
   input wire logic [1:0]  phase,
   input wire logic [3:0]  op_code,
   input wire logic [11:0] op_target,
   input wire logic        skip_true,
   input wire logic        lookup_low_valid,
   input wire logic [5:0]  irq_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   int          since_rst_reg;
   logic [11:0] vec_addr;
   wire         cycle_end = phase == 2'h3 && exec_valid;

   // saturates so it never wraps back into the start-up window
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         since_rst_reg <= 0;
      else if (since_rst_reg < STARTUP_CYCLES + 20)
         since_rst_reg <= since_rst_reg + 1;

   always_comb begin
      vec_addr = 12'h000;
      for (int i = 0; i < 6; i++)
         if (irq_ack[i]) vec_addr = 12'(4 * i + 4);
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_phase_run; phase == 2'h1 |=> phase == 2'h2 ##1 phase == 2'h3 ##1 phase == 2'h0;
   endproperty
   a_phase_run: assert property (p_phase_run) else $error("phase did not step");
   property p_fetch_edge; $changed(rom_addr) |-> $past(phase) == 2'h3; endproperty
   a_fetch_edge: assert property (p_fetch_edge) else $error("fetch moved mid cycle");
   property p_advance; cycle_end && op_code == 4'h0 |=> !exec_valid ||
      (exec_addr == $past(rom_addr) && rom_addr == $past(rom_addr) + 12'h001); endproperty
   a_advance: assert property (p_advance) else $error("no advance by one");
   property p_transfer; cycle_end && (op_code == 4'h2 || op_code == 4'h3) |=>
      !exec_valid && rom_addr == $past(op_target); endproperty
   a_transfer: assert property (p_transfer) else $error("bad transfer");
   property p_skip; cycle_end && op_code == 4'h1 && skip_true |=>
      !exec_valid && rom_addr == $past(exec_addr) + 12'h002; endproperty
   a_skip: assert property (p_skip) else $error("bad skip");
   property p_lookup; cycle_end && (op_code == 4'h6 || op_code == 4'h7) |=> (!exec_valid &&
      rom_addr[11:8] == ($past(op_code) == 4'h7 ? 4'hF : $past(exec_addr[11:8])))
      ##1 !exec_valid [*3] ##1 (lookup_low_valid && exec_valid); endproperty
   a_lookup: assert property (p_lookup) else $error("bad lookup");
   property p_vector; irq_ack != 6'h00 |-> $onehot(irq_ack) && !exec_valid && rom_addr == vec_addr;
   endproperty
   a_vector: assert property (p_vector) else $error("bad vector");
   property p_start; since_rst_reg < STARTUP_CYCLES |->
      phase == 2'h0 && !exec_valid && rom_addr == 12'h000; endproperty
   a_start: assert property (p_start) else $error("ran during start-up");
   property p_apb_answer; psel && !penable |=> pready ##1 !pready; endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("bad apb answer");
   property p_ro_high; pready && paddr == 8'h20 |->
      (pwrite ? pslverr : prdata[31:7] == 25'h0); endproperty
   a_ro_high: assert property (p_ro_high) else $error("high byte not read-only");
endmodule

bind program_sequencer seq_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .rom_addr, .exec_addr, .exec_valid, .phase, .op_code, .op_target, .skip_true,
   .lookup_low_valid, .irq_ack
);

//--- sim/tb_top.sv
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %0t mismatch got %0h exp %0h", $time, g, e); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // clock, reset, apb
   logic        pclk = 0;
   logic        presetn = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   // rom and decoder
   logic [11:0] rom_addr;
   logic [14:0] rom_data;
   logic [14:0] exec_word;
   logic [11:0] exec_addr;
   logic        exec_valid;
   logic [1:0]  phase;
   logic [3:0]  op_code;
   logic [11:0] op_target;
   logic        skip_true;
   logic [7:0]  lookup_low_byte;
   logic        lookup_low_valid;
   // interrupt sources
   logic        ext_irq_first_n = 1;
   logic        ext_irq_second_n = 1;
   logic        counter_first_ovf = 0;
   logic        counter_second_ovf = 0;
   logic        time_base_irq = 0;
   logic        rtc_irq = 0;
   logic [5:0]  irq_ack;
   // power
   logic        wake_pin = 0;
   logic        halted;
   // bookkeeping
   int          n_errors = 0;
   int          checks_done = 0;
   logic [11:0] trace [$];
   logic [7:0]  look_q [$];
   logic [5:0]  ack_q [$];

   always #2.5 pclk = ~pclk;

   program_sequencer #(.STARTUP_CYCLES(8), .SST_W(4)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rom_addr(rom_addr), .rom_data(rom_data), .exec_word(exec_word),
      .exec_addr(exec_addr), .exec_valid(exec_valid), .phase(phase), .op_code(op_code),
      .op_target(op_target), .skip_true(skip_true), .lookup_low_byte(lookup_low_byte),
      .lookup_low_valid(lookup_low_valid), .ext_irq_first_n(ext_irq_first_n),
      .ext_irq_second_n(ext_irq_second_n), .counter_first_ovf(counter_first_ovf),
      .counter_second_ovf(counter_second_ovf), .time_base_irq(time_base_irq),
      .rtc_irq(rtc_irq), .irq_ack(irq_ack), .wake_pin(wake_pin), .halted(halted));

   rom_model far (
      .pclk(pclk), .rom_addr(rom_addr), .rom_data(rom_data), .exec_word(exec_word),
      .op_code(op_code), .op_target(op_target), .skip_true(skip_true));

   // executed addresses, repeats of a self loop folded
   always @(posedge pclk) begin
      if (exec_valid === 1'b1 && phase === 2'h0 && (trace.size() == 0 || trace[$] !== exec_addr))
         trace.push_back(exec_addr);
      if (lookup_low_valid === 1'b1)
         look_q.push_back(lookup_low_byte);
      if (irq_ack !== 6'h00)
         ack_q.push_back(irq_ack);
   end

   task close_out;
      if (n_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task expire;
      n_errors++;
      $display("BAD %0t timeout", $time);
      close_out;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) expire;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_for(input int n, input bit on_acks);
      int k;
      k = 0;
      while ((on_acks ? ack_q.size() : trace.size()) < n) begin
         @(posedge pclk);
         k++;
         if (k > 400) expire;
      end
   endtask

   function automatic logic [14:0] word_of(input logic [3:0] op, input logic [10:0] t);
      return {op, t};
   endfunction

   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      apb(1'b1, 8'h1C, 32'h0000_00AB, r, e);
      apb(1'b0, 8'h1C, 32'h0, r, e);
      `CHK(r[7:0], 8'hAB)
      apb(1'b1, 8'h20, 32'h0000_0055, r, e);
      `CHK(e, 1'b1)
      apb(1'b0, 8'h3C, 32'h0, r, e);
      `CHK(e, 1'b1)
   endtask

   task automatic t_flow;
      logic [31:0] r;
      logic        e;
      logic [11:0] exp_t [8];
      exp_t = '{12'h000, 12'h100, 12'h101, 12'h103, 12'h200, 12'h104, 12'h105, 12'h106};
      wait_for(8, 1'b0);
      for (int i = 0; i < 8; i++) `CHK(trace[i], exp_t[i])
      `CHK(look_q[0], 8'h21)
      `CHK(look_q[1], 8'hA5)
      apb(1'b0, 8'h20, 32'h0, r, e);
      `CHK(r, 32'h0000_007F)
      // short jump keeps the page of the running loop
      apb(1'b1, 8'h18, 32'h0000_0008, r, e);
      wait_for(9, 1'b0);
      `CHK(trace[8], 12'h108)
   endtask

   // sources raised while disabled, then all enabled at once
   task automatic raise(input logic [5:0] m);
      logic [31:0] r;
      logic        e;
      apb(1'b1, 8'h40, 32'h0, r, e);
      @(posedge pclk);
      ext_irq_first_n <= ~m[0];
      ext_irq_second_n <= ~m[1];
      counter_first_ovf <= m[2];
      counter_second_ovf <= m[3];
      time_base_irq <= m[4];
      rtc_irq <= m[5];
      @(posedge pclk);
      {counter_first_ovf, counter_second_ovf, time_base_irq, rtc_irq} <= 4'h0;
      repeat (3) @(posedge pclk);
      {ext_irq_first_n, ext_irq_second_n} <= 2'h3;
      repeat (4) @(posedge pclk);
      apb(1'b1, 8'h40, 32'h0000_003F, r, e);
   endtask

   task automatic t_irq;
      logic [5:0] exp_a [6];
      exp_a = '{6'h01, 6'h04, 6'h20, 6'h02, 6'h08, 6'h10};
      raise(6'h25);
      wait_for(3, 1'b1);
      raise(6'h1A);
      wait_for(6, 1'b1);
      for (int i = 0; i < 6; i++) `CHK(ack_q[i], exp_a[i])
   endtask

   // halt parks the fetch address; wake reruns the start-up period first
   task automatic t_halt;
      logic [31:0] r;
      logic        e;
      int          n;
      int          k;
      logic [11:0] exp_t [4];
      exp_t = '{12'h10A, 12'h10B, 12'h10C, 12'h10D};
      repeat (40) @(posedge pclk);
      n = trace.size();
      apb(1'b1, 8'h18, 32'h0000_000A, r, e);
      k = 0;
      while (halted !== 1'b1) begin
         @(posedge pclk);
         k++;
         if (k > 400) expire;
      end
      apb(1'b0, 8'h44, 32'h0, r, e);
      `CHK(r[16:15], 2'b10)
      @(posedge pclk);
      wake_pin <= 1'b1;
      k = 0;
      while (halted !== 1'b0) begin
         @(posedge pclk);
         k++;
         if (k > 400) expire;
      end
      wake_pin <= 1'b0;
      apb(1'b0, 8'h44, 32'h0, r, e);
      `CHK(r[16:15], 2'b01)
      wait_for(n + 4, 1'b0);
      for (int i = 0; i < 4; i++) `CHK(trace[n + i], exp_t[i])
   endtask

   // six nested calls fill the stack; a pending request waits for a return
   task automatic t_full;
      logic [31:0] r;
      logic        e;
      repeat (80) @(posedge pclk);
      apb(1'b0, 8'h44, 32'h0, r, e);
      `CHK(r[14:12], 3'h6)
      raise(6'h04);
      repeat (60) @(posedge pclk);
      `CHK(ack_q.size(), 6)
      apb(1'b0, 8'h44, 32'h0, r, e);
      `CHK(r[22:17], 6'h04)
      apb(1'b1, 8'h18, 32'h0000_0051, r, e);
      wait_for(7, 1'b1);
      `CHK(ack_q[6], 6'h04)
   endtask

   initial begin
      for (int i = 0; i < 4096; i++) far.mem_reg[i] = 15'h0000;
      for (int v = 4; v <= 24; v += 4) far.mem_reg[v] = word_of(4'h5, 11'h000);
      far.mem_reg[12'h000] = word_of(4'h2, 11'h100);
      far.mem_reg[12'h101] = word_of(4'h1, 11'h400);
      far.mem_reg[12'h103] = word_of(4'h3, 11'h200);
      far.mem_reg[12'h104] = word_of(4'h6, 11'h000);
      far.mem_reg[12'h105] = word_of(4'h7, 11'h000);
      far.mem_reg[12'h106] = word_of(4'h2, 11'h106);
      far.mem_reg[12'h108] = word_of(4'h2, 11'h108);
      far.mem_reg[12'h200] = word_of(4'h4, 11'h000);
      far.mem_reg[12'h1AB] = 15'h4321;
      far.mem_reg[12'hFAB] = 15'h7FA5;
      far.mem_reg[12'h10A] = word_of(4'h9, 11'h000);
      far.mem_reg[12'h10B] = word_of(4'h1, 11'h000);
      far.mem_reg[12'h10D] = word_of(4'h3, 11'h300);
      for (int c = 0; c < 5; c++) far.mem_reg[768 + 16 * c] = word_of(4'h3, 11'(784 + 16 * c));
      far.mem_reg[12'h350] = word_of(4'h2, 11'h350);
      far.mem_reg[12'h351] = word_of(4'h4, 11'h000);
      far.mem_reg[12'h341] = word_of(4'h2, 11'h341);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_flow;
      t_irq;
      t_halt;
      t_full;
      close_out;
   end
endmodule
